// ---- src/iwc_pkg.sv ----
// Shared constants and types of the window-based I2C target
package iwc_pkg;

  // **********************************************************
  // Bus identity and command bytes
  // **********************************************************
  localparam logic [6:0] IWC_DEV_ADDR = 7'h56;
  localparam logic [7:0] IWC_ERR_BYTE = 8'hEE;
  localparam logic [7:0] IWC_CMD_BYTE = 8'hFF;
  localparam logic [7:0] IWC_REG_GLOBAL_EVENTS = 8'h11;
  localparam logic [3:0] IWC_BYTE_BITS = 4'h8;
  localparam logic [3:0] IWC_LAST_TX_BIT = 4'h7;

  // **********************************************************
  // Event sources
  // **********************************************************
  localparam int IWC_EVT_NUM = 4;
  localparam int IWC_EVT_PMODE = 0;
  localparam int IWC_EVT_TOUCH = 1;
  localparam int IWC_EVT_AUTO_TUNING = 2;
  localparam int IWC_EVT_HALL = 3;

  // **********************************************************
  // Timing
  // **********************************************************
  localparam int IWC_SYS_CLK_KHZ = 10000;
  localparam int IWC_FORCE_DLY_US = 100;
  localparam int IWC_FORCE_DLY_CYC =
    (IWC_FORCE_DLY_US * IWC_SYS_CLK_KHZ + 999) / 1000;
  localparam int IWC_TIMEOUT_MS = 500;
  localparam int IWC_TIMEOUT_CYC = IWC_TIMEOUT_MS * IWC_SYS_CLK_KHZ;
  localparam int IWC_TMR_W = 23;

  // **********************************************************
  // Reporting modes
  // **********************************************************
  typedef enum logic [1:0] {
    IWC_MODE_STREAM,
    IWC_MODE_EVENT,
    IWC_MODE_STANDALONE,
    IWC_MODE_HALT
  } iwc_mode_t;

endpackage

// ---- src/iwc_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
module iwc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // Only the second stage is visible to logic
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // iwc_sync

// ---- src/iwc_timer.sv ----
// One-shot down counter with abort, gives a pulse on expiry
`timescale 1ns/1ps
module iwc_timer #(
  parameter int W = 23
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire logic [W-1:0] load_val,
  output logic expired
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;
  logic exp_ff;
  logic nxt_exp;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_exp = 1'b0;
    if (abort)
      nxt_run = 1'b0;
    else if (start)
    begin
      nxt_cnt = load_val;
      nxt_run = 1'b1;
    end
    else if (run_ff)
    begin
      if (cnt_ff <= W'(1))
      begin
        nxt_run = 1'b0;
        nxt_exp = 1'b1;
      end
      else
        nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      exp_ff <= nxt_exp;
    end
  end

  assign expired = exp_ff;
endmodule // iwc_timer

// ---- src/iwc_target.sv ----
// Window-based I2C target: link engine and ready-window control
`timescale 1ns/1ps
// Overview of operation
// - Restart flag set forces streaming until acknowledged
// - Answer only target address 0x56
// - Stretch SCL while fetching read data
// - First written byte selects the register
// - Two bytes per address, then next address
// - Each word moves low byte first
// - Address auto-increments over consecutive registers
// - Pull ready low while window open
// - Stop releases ready and ends window
// - Access with window closed returns 0xEE
// - Read of unimplemented register returns 0xEE
// - Event mode opens on enabled events, or while any event is unread
// - Standalone mode opens cycle windows only while the restart flag is set
// - Unserviced window closes after the timeout
// - Stop-close inhibit: close only by 0xFF or the timeout
// - Streaming opens window every sensing cycle
// - Event mode waits for flag read and ack
// - Each event source enabled on its own
// - Command 0xFF plus stop forces a window
// - Forced window opens after a short delay
// - Byte 0 is low, byte 1 is high
module iwc_target
  import iwc_pkg::*;
#(
  parameter int TIMEOUT_CYC = iwc_pkg::IWC_TIMEOUT_CYC,
  parameter int FORCE_CYC = iwc_pkg::IWC_FORCE_DLY_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic lnk_clk,
  input wire logic lnk_rstn,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic rdy_o,
  output logic rdy_oe,
  input wire iwc_pkg::iwc_mode_t rpt_mode,
  input wire logic dev_reset_flag,
  input wire logic stop_close_inh,
  input wire logic [iwc_pkg::IWC_EVT_NUM-1:0] evt_en,
  input wire logic [iwc_pkg::IWC_EVT_NUM-1:0] evt_in,
  input wire logic cycle_end,
  output logic win_open,
  output logic win_closed,
  output logic [7:0] reg_addr,
  output logic reg_rd_req,
  input wire logic reg_rd_ack,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_ok,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_addr,
  output logic [15:0] reg_wr_data
);
  import iwc_pkg::*;

  // **********************************************************
  // Link domain: pin synchronisers and bus conditions
  // **********************************************************
  typedef enum {L_IDLE, L_ADDR, L_ACK, L_RX, L_FETCH, L_TX, L_RACK}
    iwc_lst_t;

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic win_l;
  logic scl_p_ff;
  logic sda_p_ff;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  iwc_sync #(.W(2)) u_pin_sync (
    .clk(lnk_clk),
    .rstn(lnk_rstn),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign bus_start = scl_s && scl_p_ff && sda_p_ff && !sda_s;
  assign bus_stop = scl_s && scl_p_ff && !sda_p_ff && sda_s;
  assign scl_rise = scl_s && !scl_p_ff;
  assign scl_fall = !scl_s && scl_p_ff;

  // **********************************************************
  // Link domain: byte engine
  // **********************************************************
  iwc_lst_t st_ff, nxt_st;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] lo_ff, nxt_lo;
  logic [7:0] hi_ff, nxt_hi;
  logic [7:0] wa_ff, nxt_wa;
  logic [15:0] wd_ff, nxt_wd;
  logic rw_ff, nxt_rw;
  logic got_reg_ff, nxt_got_reg;
  logic sel_ff, nxt_sel;
  logic cmd_ff, nxt_cmd;
  logic ack_ok_ff, nxt_ack_ok;
  logic sda_oe_ff, nxt_sda_oe;
  logic scl_oe_ff, nxt_scl_oe;
  logic rd_req_ff, nxt_rd_req;
  logic wr_en_ff, nxt_wr_en;
  logic stop_tgl_ff, nxt_stop_tgl;
  logic cmd_tgl_ff, nxt_cmd_tgl;
  logic evrd_tgl_ff, nxt_evrd_tgl;
  logic pin_lo_ff;
  logic [15:0] fetched;

  // Unimplemented register or closed window reads as the error byte
  assign fetched = (reg_rd_ok && win_l) ? reg_rd_data :
                   {IWC_ERR_BYTE, IWC_ERR_BYTE};

  always_comb
  begin
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_addr = addr_ff;
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    nxt_wa = wa_ff;
    nxt_wd = wd_ff;
    nxt_rw = rw_ff;
    nxt_got_reg = got_reg_ff;
    nxt_sel = sel_ff;
    nxt_cmd = cmd_ff;
    nxt_ack_ok = ack_ok_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_rd_req = rd_req_ff;
    nxt_wr_en = 1'b0;
    nxt_stop_tgl = stop_tgl_ff;
    nxt_cmd_tgl = cmd_tgl_ff;
    nxt_evrd_tgl = evrd_tgl_ff;
    if (bus_start)
    begin
      nxt_st = L_ADDR;
      nxt_bit = '0;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
      nxt_rd_req = 1'b0;
    end
    else if (bus_stop)
    begin
      nxt_st = L_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
      nxt_rd_req = 1'b0;
      nxt_got_reg = 1'b0;
      nxt_stop_tgl = !stop_tgl_ff;
      // A lone 0xFF then stop is the window command
      if (cmd_ff)
        nxt_cmd_tgl = !cmd_tgl_ff;
      nxt_cmd = 1'b0;
    end
    else
    begin
      unique case (st_ff)
        L_IDLE: ;
        L_ADDR, L_RX:
        begin
          if (scl_rise)
          begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end
          else if (scl_fall && bit_ff == IWC_BYTE_BITS)
          begin
            nxt_bit = '0;
            nxt_sda_oe = 1'b1;
            nxt_st = L_ACK;
            if (st_ff == L_ADDR)
            begin
              if (sh_ff[7:1] == IWC_DEV_ADDR)
              begin
                nxt_rw = sh_ff[0];
                nxt_sel = 1'b0;
                nxt_cmd = 1'b0;
                if (!sh_ff[0])
                  nxt_got_reg = 1'b0;
              end
              else
              begin
                nxt_sda_oe = 1'b0;
                nxt_st = L_IDLE;
              end
            end
            else if (!got_reg_ff)
            begin
              nxt_addr = sh_ff;
              nxt_got_reg = 1'b1;
              nxt_sel = 1'b0;
              nxt_cmd = (sh_ff == IWC_CMD_BYTE);
            end
            else
            begin
              nxt_cmd = 1'b0;
              if (!sel_ff)
              begin
                nxt_lo = sh_ff;
                nxt_sel = 1'b1;
              end
              else
              begin
                // Writes outside a window are acked but dropped
                nxt_wr_en = win_l;
                nxt_wa = addr_ff;
                nxt_wd = {sh_ff, lo_ff};
                nxt_addr = addr_ff + 8'h01;
                nxt_sel = 1'b0;
              end
            end
          end
        end
        L_ACK:
        begin
          if (scl_fall)
          begin
            nxt_sda_oe = 1'b0;
            if (rw_ff)
            begin
              nxt_st = L_FETCH;
              nxt_scl_oe = 1'b1;
              nxt_rd_req = !sel_ff && win_l;
            end
            else
              nxt_st = L_RX;
          end
        end
        L_FETCH:
        begin
          if (rd_req_ff)
          begin
            // Clock held low until the register file answers
            if (reg_rd_ack)
            begin
              nxt_rd_req = 1'b0;
              nxt_lo = fetched[7:0];
              nxt_hi = fetched[15:8];
              nxt_sh = fetched[7:0];
              nxt_sda_oe = !fetched[7];
              nxt_scl_oe = 1'b0;
              nxt_bit = '0;
              nxt_st = L_TX;
              if (addr_ff == IWC_REG_GLOBAL_EVENTS && win_l)
                nxt_evrd_tgl = !evrd_tgl_ff;
            end
          end
          else
          begin
            if (!sel_ff)
            begin
              nxt_hi = IWC_ERR_BYTE;
              nxt_sh = IWC_ERR_BYTE;
              nxt_sda_oe = !IWC_ERR_BYTE[7];
            end
            else
            begin
              nxt_sh = hi_ff;
              nxt_sda_oe = !hi_ff[7];
            end
            nxt_scl_oe = 1'b0;
            nxt_bit = '0;
            nxt_st = L_TX;
          end
        end
        L_TX:
        begin
          if (scl_fall)
          begin
            if (bit_ff == IWC_LAST_TX_BIT)
            begin
              nxt_sda_oe = 1'b0;
              nxt_bit = '0;
              nxt_st = L_RACK;
            end
            else
            begin
              nxt_bit = bit_ff + 4'h1;
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_sda_oe = !sh_ff[6];
            end
          end
        end
        L_RACK:
        begin
          if (scl_rise)
            nxt_ack_ok = !sda_s;
          else if (scl_fall)
          begin
            if (ack_ok_ff)
            begin
              nxt_st = L_FETCH;
              nxt_scl_oe = 1'b1;
              if (sel_ff)
              begin
                nxt_sel = 1'b0;
                nxt_addr = addr_ff + 8'h01;
                nxt_rd_req = win_l;
              end
              else
                nxt_sel = 1'b1;
            end
            else
              nxt_st = L_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge lnk_clk)
  begin
    if (!lnk_rstn)
    begin
      scl_p_ff <= 1'b1;
      sda_p_ff <= 1'b1;
      st_ff <= L_IDLE;
      bit_ff <= '0;
      sh_ff <= '0;
      addr_ff <= '0;
      lo_ff <= '0;
      hi_ff <= '0;
      wa_ff <= '0;
      wd_ff <= '0;
      rw_ff <= 1'b0;
      got_reg_ff <= 1'b0;
      sel_ff <= 1'b0;
      cmd_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      wr_en_ff <= 1'b0;
      stop_tgl_ff <= 1'b0;
      cmd_tgl_ff <= 1'b0;
      evrd_tgl_ff <= 1'b0;
      pin_lo_ff <= 1'b0;
    end
    else
    begin
      scl_p_ff <= scl_s;
      sda_p_ff <= sda_s;
      st_ff <= nxt_st;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      addr_ff <= nxt_addr;
      lo_ff <= nxt_lo;
      hi_ff <= nxt_hi;
      wa_ff <= nxt_wa;
      wd_ff <= nxt_wd;
      rw_ff <= nxt_rw;
      got_reg_ff <= nxt_got_reg;
      sel_ff <= nxt_sel;
      cmd_ff <= nxt_cmd;
      ack_ok_ff <= nxt_ack_ok;
      sda_oe_ff <= nxt_sda_oe;
      scl_oe_ff <= nxt_scl_oe;
      rd_req_ff <= nxt_rd_req;
      wr_en_ff <= nxt_wr_en;
      stop_tgl_ff <= nxt_stop_tgl;
      cmd_tgl_ff <= nxt_cmd_tgl;
      evrd_tgl_ff <= nxt_evrd_tgl;
      pin_lo_ff <= 1'b0;
    end
  end

  assign scl_o = pin_lo_ff;
  assign sda_o = pin_lo_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign reg_addr = addr_ff;
  assign reg_rd_req = rd_req_ff;
  assign reg_wr_en = wr_en_ff;
  assign reg_wr_addr = wa_ff;
  assign reg_wr_data = wd_ff;

  // **********************************************************
  // Domain crossings
  // **********************************************************
  logic [2:0] tgl_s;
  logic [2:0] tgl_p_ff;
  logic stop_ev;
  logic cmd_ev;
  logic evrd_ev;
  logic win_ff;

  // Toggles carry link events; the window state goes back as a level
  iwc_sync #(.W(3)) u_evt_sync (
    .clk(sys_clk),
    .rstn(rstn),
    .d({stop_tgl_ff, cmd_tgl_ff, evrd_tgl_ff}),
    .q(tgl_s)
  );

  iwc_sync #(.W(1)) u_win_sync (
    .clk(lnk_clk),
    .rstn(lnk_rstn),
    .d(win_ff),
    .q(win_l)
  );

  assign stop_ev = tgl_s[2] ^ tgl_p_ff[2];
  assign cmd_ev = tgl_s[1] ^ tgl_p_ff[1];
  assign evrd_ev = tgl_s[0] ^ tgl_p_ff[0];

  // **********************************************************
  // System domain: ready window control
  // **********************************************************
  typedef enum {W_IDLE, W_WAIT, W_OPEN} iwc_wst_t;

  iwc_wst_t wst_ff, nxt_wst;
  logic pend_ff, nxt_pend;
  logic seen_ff, nxt_seen;
  logic closed_ff, nxt_closed;
  logic rdy_lo_ff;
  logic evt_hit;
  logic stream_now;
  logic go_open;
  logic go_wait;
  logic go_close;
  logic force_done;
  logic tmo_done;

  // Quadrature outputs live elsewhere and ignore the reporting mode
  assign evt_hit = |(evt_in & evt_en);
  assign stream_now = dev_reset_flag ||
                      rpt_mode == IWC_MODE_STREAM ||
                      (rpt_mode == IWC_MODE_EVENT && pend_ff);

  always_comb
  begin
    nxt_wst = wst_ff;
    nxt_closed = 1'b0;
    go_open = 1'b0;
    go_wait = 1'b0;
    go_close = 1'b0;
    unique case (wst_ff)
      W_IDLE:
      begin
        if (cmd_ev)
        begin
          go_wait = 1'b1;
          nxt_wst = W_WAIT;
        end
        else if (cycle_end && (stream_now ||
                 (rpt_mode == IWC_MODE_EVENT &&
                  (seen_ff || evt_hit))))
        begin
          go_open = 1'b1;
          nxt_wst = W_OPEN;
        end
      end
      W_WAIT:
      begin
        if (force_done)
        begin
          go_open = 1'b1;
          nxt_wst = W_OPEN;
        end
      end
      W_OPEN:
      begin
        // Inhibit leaves the command as the only host-side close
        if (cmd_ev || (stop_ev && !stop_close_inh) ||
            tmo_done)
        begin
          go_close = 1'b1;
          nxt_closed = 1'b1;
          nxt_wst = W_IDLE;
        end
      end
    endcase
    // Set wins over clear for the pending flag; opening clears the seen flag
    nxt_pend = (pend_ff && !evrd_ev) || (|evt_in);
    nxt_seen = go_open ? 1'b0 : (seen_ff || evt_hit);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      tgl_p_ff <= '0;
      wst_ff <= W_IDLE;
      pend_ff <= 1'b0;
      seen_ff <= 1'b0;
      closed_ff <= 1'b0;
      win_ff <= 1'b0;
      rdy_lo_ff <= 1'b0;
    end
    else
    begin
      tgl_p_ff <= tgl_s;
      wst_ff <= nxt_wst;
      pend_ff <= nxt_pend;
      seen_ff <= nxt_seen;
      closed_ff <= nxt_closed;
      win_ff <= (nxt_wst == W_OPEN);
      rdy_lo_ff <= 1'b0;
    end
  end

  // Delay is the shortest typical figure; longer suits slow firmware
  iwc_timer #(.W(IWC_TMR_W)) u_force_tmr (
    .clk(sys_clk),
    .rstn(rstn),
    .start(go_wait),
    .abort(1'b0),
    .load_val(IWC_TMR_W'(FORCE_CYC)),
    .expired(force_done)
  );

  iwc_timer #(.W(IWC_TMR_W)) u_tmo_tmr (
    .clk(sys_clk),
    .rstn(rstn),
    .start(go_open),
    .abort(go_close),
    .load_val(IWC_TMR_W'(TIMEOUT_CYC)),
    .expired(tmo_done)
  );

  assign rdy_o = rdy_lo_ff;
  assign rdy_oe = win_ff;
  assign win_open = win_ff;
  assign win_closed = closed_ff;
endmodule // iwc_target

// ---- sim/iwc_target_assertions.sv ----
// Checker of the window-based I2C target
`timescale 1ns/1ps
module iwc_target_chk
  import iwc_pkg::*;
#(
  parameter int TIMEOUT_CYC = 2000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic lnk_clk,
  input wire logic lnk_rstn,
  input wire logic scl_oe,
  input wire logic rdy_o,
  input wire logic rdy_oe,
  input wire iwc_pkg::iwc_mode_t rpt_mode,
  input wire logic dev_reset_flag,
  input wire logic cycle_end,
  input wire logic win_open,
  input wire logic win_closed,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_req,
  input wire logic reg_rd_ack,
  input wire logic reg_wr_en
);
  // ****************************
  // Window checks
  // ****************************
  int open_cnt;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !win_open) open_cnt <= 0;
    else open_cnt <= open_cnt + 1;
  end
  property p_rdy_lvl;
    @(posedge sys_clk) disable iff (!rstn) win_open == rdy_oe && !rdy_o;
  endproperty
  a_rdy_lvl: assert property (p_rdy_lvl) else $error("ready level");
  property p_stream;
    @(posedge sys_clk) disable iff (!rstn)
      cycle_end && !win_open && rpt_mode == IWC_MODE_STREAM |=> win_open;
  endproperty
  a_stream: assert property (p_stream) else $error("no stream window");
  property p_rst_flag;
    @(posedge sys_clk) disable iff (!rstn)
      cycle_end && !win_open && dev_reset_flag |=> win_open;
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("restart");
  property p_alone;
    @(posedge sys_clk) disable iff (!rstn) cycle_end && !win_open &&
      !dev_reset_flag && rpt_mode == IWC_MODE_STANDALONE |=> !win_open;
  endproperty
  a_alone: assert property (p_alone) else $error("standalone window");
  property p_close;
    @(posedge sys_clk) disable iff (!rstn)
      win_closed |-> !win_open && $past(win_open);
  endproperty
  a_close: assert property (p_close) else $error("close pulse");
  // Counter keeps the bound off a long repetition
  property p_tmo;
    @(posedge sys_clk) disable iff (!rstn) open_cnt <= TIMEOUT_CYC + 4;
  endproperty
  a_tmo: assert property (p_tmo) else $error("window too long");
  // ****************************
  // Link checks
  // ****************************
  property p_rd_hold;
    @(posedge lnk_clk) disable iff (!lnk_rstn)
      reg_rd_req && !reg_rd_ack |=> reg_rd_req && $stable(reg_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped");
  property p_stretch;
    @(posedge lnk_clk) disable iff (!lnk_rstn)
      reg_rd_req && $past(reg_rd_req) |-> scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");
  property p_wr_pulse;
    @(posedge lnk_clk) disable iff (!lnk_rstn) reg_wr_en |=> !reg_wr_en;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse");
endmodule // iwc_target_chk
bind iwc_target iwc_target_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_iwc_target_chk (
  .sys_clk(sys_clk), .rstn(rstn), .lnk_clk(lnk_clk), .lnk_rstn(lnk_rstn),
  .scl_oe(scl_oe), .rdy_o(rdy_o), .rdy_oe(rdy_oe), .rpt_mode(rpt_mode),
  .dev_reset_flag(dev_reset_flag), .cycle_end(cycle_end),
  .win_open(win_open), .win_closed(win_closed), .reg_addr(reg_addr),
  .reg_rd_req(reg_rd_req), .reg_rd_ack(reg_rd_ack), .reg_wr_en(reg_wr_en)
);

// ---- sim/iwc_host.sv ----
// Behavioural I2C controller standing in for the host
`timescale 1ns/1ps
module iwc_host #(
  parameter int HALF_NS = 250
) (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic hang
);
  // ****************************
  // Bus primitives
  // ****************************
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang = 1'b0;
  end
  // Release SCL, bounded wait while the target stretches it
  task rise;
    int k;
    k = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && k < 4000)
    begin
      #10;
      k++;
    end
    if (k == 4000) hang = 1'b1;
    #HALF_NS;
  endtask
  // Also serves as repeated start
  task start;
    sda_low = 1'b0;
    #HALF_NS;
    rise();
    sda_low = 1'b1;
    #HALF_NS;
    scl_low = 1'b1;
  endtask
  // Data moves 50 ns after SCL falls, never with it
  task wbit(input logic b);
    #50;
    sda_low = !b;
    #HALF_NS;
    rise();
    scl_low = 1'b1;
  endtask
  task rbit(output logic b);
    #50;
    sda_low = 1'b0;
    #HALF_NS;
    rise();
    b = sda;
    scl_low = 1'b1;
  endtask
  task wbyte(input logic [7:0] d, output logic nack);
    int i;
    for (i = 7; i >= 0; i--) wbit(d[i]);
    rbit(nack);
  endtask
  task rbyte(output logic [7:0] d, input logic last);
    int i;
    for (i = 7; i >= 0; i--) rbit(d[i]);
    wbit(last);
  endtask
  task stop;
    #50;
    sda_low = 1'b1;
    #HALF_NS;
    rise();
    sda_low = 1'b0;
    #HALF_NS;
  endtask
endmodule // iwc_host

// ---- sim/tb_top.sv ----
// Testbench of the window-based I2C target
`timescale 1ns/1ps
module tb_top;
  import iwc_pkg::*;
  // ****************************
  // Set-up
  // ****************************
  localparam int TMO = 2000;
  localparam int FRC = 20;
  logic sys_clk, rstn, lnk_clk, lnk_rstn, h_scl, h_sda, hang, nk;
  logic scl_o, scl_oe, sda_o, sda_oe, rdy_o, rdy_oe, win_open, win_closed;
  iwc_mode_t rpt_mode;
  logic dev_reset_flag, stop_close_inh, cycle_end, reg_rd_req, reg_wr_en;
  logic [3:0] evt_en, evt_in;
  logic [7:0] reg_addr, reg_wr_addr;
  logic [15:0] reg_wr_data;
  logic [15:0] reg_rd_data = 16'h0000;
  logic reg_rd_ack = 1'b0;
  logic reg_rd_ok = 1'b0;
  logic [23:0] wr_last = 24'h000000;
  int wr_n = 0;
  int miscompares, compares, n, i, w0;
  logic [7:0] rb [4];
  // A pin the device enables shows its output level, low when correct
  wire scl = !(h_scl | (scl_oe && !scl_o));
  wire sda = !(h_sda | (sda_oe && !sda_o));
  wire rdy = !(rdy_oe && !rdy_o);
  int closes = 0;
  iwc_target #(.TIMEOUT_CYC(TMO), .FORCE_CYC(FRC)) i_iwc_target (
    .sys_clk(sys_clk), .rstn(rstn), .lnk_clk(lnk_clk), .lnk_rstn(lnk_rstn),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .rdy_o(rdy_o), .rdy_oe(rdy_oe), .rpt_mode(rpt_mode),
    .dev_reset_flag(dev_reset_flag), .stop_close_inh(stop_close_inh),
    .evt_en(evt_en), .evt_in(evt_in), .cycle_end(cycle_end),
    .win_open(win_open), .win_closed(win_closed), .reg_addr(reg_addr),
    .reg_rd_req(reg_rd_req), .reg_rd_ack(reg_rd_ack),
    .reg_rd_data(reg_rd_data), .reg_rd_ok(reg_rd_ok),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data));
  iwc_host i_iwc_host (.scl(scl), .sda(sda), .scl_low(h_scl),
    .sda_low(h_sda), .hang(hang));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    lnk_clk = 1'b0;
    #3;
    forever #6 lnk_clk = ~lnk_clk;
  end
  always @(posedge sys_clk)
    if (win_closed) closes <= closes + 1;
  // Register store stand-in: addresses 0x80 and up are unimplemented
  always @(posedge lnk_clk)
  begin
    reg_rd_ack <= reg_rd_req && !reg_rd_ack;
    reg_rd_data <= {reg_addr ^ 8'h5A, reg_addr};
    reg_rd_ok <= !reg_addr[7];
    if (reg_wr_en)
    begin
      wr_n <= wr_n + 1;
      wr_last <= {reg_wr_addr, reg_wr_data};
    end
  end
  // ****************************
  // Tasks
  // ****************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task chk_win(input logic v);
    #1;
    chk({win_open, rdy}, {v, !v});
  endtask
  task ce(input logic [3:0] e);
    @(posedge sys_clk);
    cycle_end <= 1'b1;
    evt_in <= e;
    @(posedge sys_clk);
    cycle_end <= 1'b0;
    evt_in <= 4'h0;
    cyc(2);
  endtask
  task wait_win(input logic v, input int lim);
    n = 0;
    while (win_open !== v)
    begin
      if (n == lim)
      begin
        miscompares++;
        finish_test();
      end
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task rd(input logic [7:0] r, input int k);
    int j;
    i_iwc_host.start();
    i_iwc_host.wbyte(8'hAC, nk);
    chk(nk, 0);
    i_iwc_host.wbyte(r, nk);
    i_iwc_host.start();
    i_iwc_host.wbyte(8'hAD, nk);
    chk(nk, 0);
    for (j = 0; j < k; j++) i_iwc_host.rbyte(rb[j], j == k - 1);
    i_iwc_host.stop();
  endtask
  // Bytes of d go out low byte first
  task wr(input logic [7:0] r, input logic [31:0] d, input int k);
    int j;
    i_iwc_host.start();
    i_iwc_host.wbyte(8'hAC, nk);
    i_iwc_host.wbyte(r, nk);
    for (j = 0; j < k; j++) i_iwc_host.wbyte(d[8*j +: 8], nk);
    i_iwc_host.stop();
  endtask
  // ****************************
  // Sequence
  // ****************************
  initial
  begin
    miscompares = 0;
    compares = 0;
    rstn = 1'b0;
    lnk_rstn = 1'b0;
    rpt_mode = IWC_MODE_STANDALONE;
    dev_reset_flag = 1'b1;
    stop_close_inh = 1'b0;
    evt_en = 4'h0;
    evt_in = 4'h0;
    cycle_end = 1'b0;
    cyc(20);
    rstn <= 1'b1;
    lnk_rstn <= 1'b1;
    cyc(4);
    ce(4'h0);
    chk_win(1);
    rd(8'h10, 4);
    for (i = 0; i < 4; i++)
      chk(rb[i], i[0] ? (8'h10 + i[1]) ^ 8'h5A : 8'h10 + i[1]);
    wait_win(0, 50);
    w0 = wr_n;
    rd(8'h10, 2);
    chk({rb[0], rb[1]}, 16'hEEEE);
    wr(8'h20, 32'h1234, 2);
    chk(wr_n, w0);
    i_iwc_host.start();
    i_iwc_host.wbyte(8'hA6, nk);
    i_iwc_host.stop();
    chk(nk, 1);
    @(posedge sys_clk);
    dev_reset_flag <= 1'b0;
    ce(4'h0);
    chk_win(0);
    wr(IWC_CMD_BYTE, 0, 0);
    wait_win(1, FRC + 60);
    chk(n >= FRC, 1);
    wait_win(0, TMO + 20);
    chk(n >= TMO - 20, 1);
    @(posedge sys_clk);
    rpt_mode <= IWC_MODE_STREAM;
    stop_close_inh <= 1'b1;
    ce(4'h0);
    chk_win(1);
    wr(8'h20, 32'h56781234, 4);
    chk(wr_last, 24'h215678);
    chk(wr_n, w0 + 2);
    rd(8'hF0, 2);
    chk({rb[0], rb[1]}, 16'hEEEE);
    chk_win(1);
    wr(IWC_CMD_BYTE, 0, 0);
    wait_win(0, 50);
    @(posedge sys_clk);
    stop_close_inh <= 1'b0;
    rpt_mode <= IWC_MODE_EVENT;
    ce(4'h0);
    chk_win(0);
    ce(4'h2);
    chk_win(0);
    ce(4'h0);
    chk_win(1);
    rd(IWC_REG_GLOBAL_EVENTS, 2);
    wait_win(0, 50);
    for (i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      evt_en <= 4'h1 << i;
      ce(4'h1 << i);
      chk_win(1);
      rd(IWC_REG_GLOBAL_EVENTS, 2);
      wait_win(0, 50);
      ce(4'h0);
      chk_win(0);
    end
    chk(hang, 0);
    chk(closes, 8);
    finish_test();
  end
endmodule // tb_top
